// ===== include/prot_defs.svh
// Register offsets, field positions, reset values and widths of the protection trip aggregator
`ifndef PROT_DEFS_SVH
`define PROT_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PROT_OFS_CTRL      8'h00
`define PROT_OFS_SUPV_ONLY 8'h04
`define PROT_OFS_PHASE_CAP 8'h08
`define PROT_OFS_STATUS    8'h0c
`define PROT_OFS_IRQ_STAT  8'h10
`define PROT_OFS_IRQ_EN    8'h14
`define PROT_OFS_IRQ_CLR   8'h18

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define PROT_CTRL_FUNC        0
`define PROT_CTRL_EXT_PERMIT  1
`define PROT_CTRL_PERM_INHIB  2
`define PROT_CTRL_TEMP_PERMIT 3
`define PROT_CTRL_W           4

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define PROT_ST_ALARM     0
`define PROT_ST_TRIP      1
`define PROT_ST_AVAIL     2
`define PROT_ST_ACTIVE    3
`define PROT_ST_BLOCKED   4
`define PROT_ST_TRIP_BLK  5
`define PROT_ST_W         6

// ----------------------------------------------------------------
// Interrupt event bits
// ----------------------------------------------------------------
`define PROT_EV_TRIP      0
`define PROT_EV_ALARM     1
`define PROT_EV_BLOCKED   2
`define PROT_EV_UNAVAIL   3
`define PROT_EV_W         4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PROT_CTRL_RST     4'h1
`define PROT_IRQ_EN_RST   4'h0

// ----------------------------------------------------------------
// Widths and timing
// ----------------------------------------------------------------
`define PROT_ADDR_W       8
`define PROT_DATA_W       32
`define PROT_PHASES       3
`define PROT_SYNC_STAGES  2

`endif

// ===== include/prot_pkg.sv
// Types shared by the protection trip aggregator files
`include "prot_defs.svh"

package prot_pkg;
  typedef logic [`PROT_ADDR_W-1:0] reg_addr_t;
  typedef logic [`PROT_DATA_W-1:0] reg_data_t;
  typedef logic [`PROT_CTRL_W-1:0] ctrl_t;
  typedef logic [`PROT_EV_W-1:0]   event_t;
  typedef logic [`PROT_PHASES-1:0] phase_t;
endpackage

// ===== src/sync_vec.sv
// Two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/10ps

module sync_vec #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb
  begin
    meta_d = d;
    q_d    = meta_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      q      <= q_d;
    end
  end

endmodule

// ===== src/protection_trip_aggregator.sv
// Master protection supervisor: gating, blockings, collective alarms and trips, trip commands
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "prot_defs.svh"

// Operation
// RL1: Inactive function or blocked master drops active
// RL2: Permitted external block inputs block all protection
// RL3: Permanent inhibit suppresses every trip command
// RL4: Permitted temporary inhibit input suppresses trip commands
// RL5: Forward element decisions only when not supervision-only
// RL6: Supervision-only elements stay local, no command
// RL7: General alarm is OR of forwarded alarms
// RL8: Elements trip only after their own delay
// RL9: General trip is OR of forwarded trips
// RL10: General trip issues commands unless inhibited
// RL11: Per-phase collectives from capable, forwarded elements
// RL12: Available needs no setting change, values OK
// RL13: Inputs sampled, outputs update next clock edge (asynchronous inputs: third edge, after two sync stages)
module protection_trip_aggregator #(
  parameter int N_ELEM = 8
) (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  // Register port
  input  wire prot_pkg::reg_addr_t      addr,
  input  wire prot_pkg::reg_data_t      wr_data,
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  output prot_pkg::reg_data_t           rd_data,
  // Asynchronous blocking and condition inputs
  input  wire logic                     block_input_a,
  input  wire logic                     block_input_b,
  input  wire logic                     temp_trip_inhibit_input,
  input  wire logic                     setting_change_busy,
  input  wire logic                     meas_ok,
  // Protection elements
  input  wire logic [N_ELEM-1:0]        elem_alarm,
  input  wire logic [N_ELEM-1:0]        elem_trip,
  input  wire logic [3*N_ELEM-1:0]      elem_phase_alarm,
  input  wire logic [3*N_ELEM-1:0]      elem_phase_trip,
  // Collective state
  output logic                          prot_available,
  output logic                          prot_active,
  output logic                          master_blocked_state,
  output logic                          trip_inhibited,
  output logic                          general_alarm,
  output logic                          general_trip,
  output logic                          phase1_collective_alarm,
  output logic                          phase2_collective_alarm,
  output logic                          phase3_collective_alarm,
  output logic                          phase1_collective_trip,
  output logic                          phase2_collective_trip,
  output logic                          phase3_collective_trip,
  output logic [N_ELEM-1:0]             trip_command_out,
  // Interrupt
  output logic                          irq
);
  import prot_pkg::*;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  generate
    if (N_ELEM < 1 || N_ELEM > `PROT_DATA_W)
    begin : g_bad_n
      $error("N_ELEM must lie between 1 and 32");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [4:0] async_in;
  logic [4:0] async_s;
  logic       blk_a_s;
  logic       blk_b_s;
  logic       temp_in_s;
  logic       busy_s;
  logic       meas_ok_s;

  assign async_in = {meas_ok, setting_change_busy, temp_trip_inhibit_input, block_input_b, block_input_a};
  sync_vec #(
    .W (5)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       (async_in),
    .q       (async_s)
  );
  assign {meas_ok_s, busy_s, temp_in_s, blk_b_s, blk_a_s} = async_s;

  // ----------------------------------------------------------------
  // Settings registers
  // ----------------------------------------------------------------
  ctrl_t             ctrl_q;
  ctrl_t             ctrl_d;
  logic [N_ELEM-1:0] supv_only_q;
  logic [N_ELEM-1:0] supv_only_d;
  logic [N_ELEM-1:0] phase_cap_q;
  logic [N_ELEM-1:0] phase_cap_d;
  event_t            irq_en_q;
  event_t            irq_en_d;

  always_comb
  begin
    ctrl_d      = ctrl_q;
    supv_only_d = supv_only_q;
    phase_cap_d = phase_cap_q;
    irq_en_d    = irq_en_q;
    if (wr_en)
    begin
      case (addr)
        `PROT_OFS_CTRL:      ctrl_d      = wr_data[`PROT_CTRL_W-1:0];
        `PROT_OFS_SUPV_ONLY: supv_only_d = wr_data[N_ELEM-1:0];
        `PROT_OFS_PHASE_CAP: phase_cap_d = wr_data[N_ELEM-1:0];
        `PROT_OFS_IRQ_EN:    irq_en_d    = wr_data[`PROT_EV_W-1:0];
        default:             ctrl_d      = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q      <= `PROT_CTRL_RST;
      supv_only_q <= '0;
      phase_cap_q <= '1;
      irq_en_q    <= `PROT_IRQ_EN_RST;
    end
    else
    begin
      ctrl_q      <= ctrl_d;
      supv_only_q <= supv_only_d;
      phase_cap_q <= phase_cap_d;
      irq_en_q    <= irq_en_d;
    end
  end

  // ----------------------------------------------------------------
  // Availability, blocking and forwarding
  // ----------------------------------------------------------------
  logic              avail_c;
  logic              blocked_c;
  logic              active_c;
  logic              trip_blk_c;
  logic [N_ELEM-1:0] fwd_mask;
  logic [N_ELEM-1:0] fwd_alarm;
  logic [N_ELEM-1:0] fwd_trip;
  phase_t            ph_alarm_c;
  phase_t            ph_trip_c;
  always_comb
  begin
    avail_c    = !busy_s && meas_ok_s;                                              // RL12
    blocked_c  = ctrl_q[`PROT_CTRL_EXT_PERMIT] && (blk_a_s || blk_b_s);             // RL2
    active_c   = ctrl_q[`PROT_CTRL_FUNC] && avail_c && !blocked_c;                  // RL1 RL12
    trip_blk_c = ctrl_q[`PROT_CTRL_PERM_INHIB]                                      // RL3
               || (ctrl_q[`PROT_CTRL_TEMP_PERMIT] && temp_in_s);                     // RL4
    fwd_mask   = ~supv_only_q & {N_ELEM{active_c}};                                 // RL5 RL6
    fwd_alarm  = elem_alarm & fwd_mask;
    fwd_trip   = elem_trip & fwd_mask;                                              // RL8
  end

  // Per-phase collectives only see single-phase capable elements
  generate
    for (genvar p = 0; p < `PROT_PHASES; p++)
    begin : g_phase
      assign ph_alarm_c[p] = |(elem_phase_alarm[p*N_ELEM +: N_ELEM] & fwd_mask & phase_cap_q);   // RL11
      assign ph_trip_c[p]  = |(elem_phase_trip[p*N_ELEM +: N_ELEM] & fwd_mask & phase_cap_q);    // RL11
    end
  endgenerate

  // ----------------------------------------------------------------
  // Collective outputs
  // ----------------------------------------------------------------
  phase_t            ph_alarm_q;
  phase_t            ph_trip_q;
  logic [N_ELEM-1:0] cmd_d;
  logic              gen_alarm_d;
  logic              gen_trip_d;
  always_comb
  begin
    gen_alarm_d = |fwd_alarm;                                                       // RL7
    gen_trip_d  = |fwd_trip;                                                        // RL9
    cmd_d       = fwd_trip & {N_ELEM{gen_trip_d && !trip_blk_c}};                   // RL10 RL6
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prot_available       <= 1'b0;
      prot_active          <= 1'b0;
      master_blocked_state <= 1'b0;
      trip_inhibited       <= 1'b0;
      general_alarm        <= 1'b0;
      general_trip         <= 1'b0;
      ph_alarm_q           <= '0;
      ph_trip_q            <= '0;
      trip_command_out     <= '0;
    end
    else
    begin
      prot_available       <= avail_c;                                              // RL13
      prot_active          <= active_c;
      master_blocked_state <= blocked_c;
      trip_inhibited       <= trip_blk_c;
      general_alarm        <= gen_alarm_d;
      general_trip         <= gen_trip_d;
      ph_alarm_q           <= ph_alarm_c;
      ph_trip_q            <= ph_trip_c;
      trip_command_out     <= cmd_d;
    end
  end

  assign phase1_collective_alarm = ph_alarm_q[0];
  assign phase2_collective_alarm = ph_alarm_q[1];
  assign phase3_collective_alarm = ph_alarm_q[2];
  assign phase1_collective_trip  = ph_trip_q[0];
  assign phase2_collective_trip  = ph_trip_q[1];
  assign phase3_collective_trip  = ph_trip_q[2];

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  event_t irq_stat_q;
  event_t irq_stat_d;
  event_t ev_c;
  event_t clr_c;
  logic   irq_d;
  always_comb
  begin
    ev_c                   = '0;
    ev_c[`PROT_EV_TRIP]    = gen_trip_d && !general_trip;
    ev_c[`PROT_EV_ALARM]   = gen_alarm_d && !general_alarm;
    ev_c[`PROT_EV_BLOCKED] = blocked_c && !master_blocked_state;
    ev_c[`PROT_EV_UNAVAIL] = !avail_c && prot_available;
    clr_c                  = (wr_en && addr == `PROT_OFS_IRQ_CLR) ? wr_data[`PROT_EV_W-1:0] : '0;
    // A new event beats a clear in the same cycle
    irq_stat_d             = (irq_stat_q & ~clr_c) | ev_c;
    irq_d                  = |(irq_stat_d & irq_en_d);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat_q <= '0;
      irq        <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq        <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  reg_data_t rd_data_d;
  always_comb
  begin
    rd_data_d = '0;
    if (rd_en)
    begin
      case (addr)
        `PROT_OFS_CTRL:      rd_data_d[`PROT_CTRL_W-1:0] = ctrl_q;
        `PROT_OFS_SUPV_ONLY: rd_data_d[N_ELEM-1:0]       = supv_only_q;
        `PROT_OFS_PHASE_CAP: rd_data_d[N_ELEM-1:0]       = phase_cap_q;
        `PROT_OFS_STATUS:    rd_data_d[`PROT_ST_W-1:0]   = {trip_inhibited, master_blocked_state, prot_active,
                                                            prot_available, general_trip, general_alarm};
        `PROT_OFS_IRQ_STAT:  rd_data_d[`PROT_EV_W-1:0]   = irq_stat_q;
        `PROT_OFS_IRQ_EN:    rd_data_d[`PROT_EV_W-1:0]   = irq_en_q;
        default:             rd_data_d                   = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= rd_data_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_inactive_drops_active: assert property (                                        // RL1
    $past(!ctrl_q[`PROT_CTRL_FUNC] || blocked_c) |-> !prot_active)
    else $error("Protection active while function off or master blocked");
  a_ext_block_holds: assert property (                                              // RL2
    (ctrl_q[`PROT_CTRL_EXT_PERMIT] && (blk_a_s || blk_b_s)) |=> (master_blocked_state && general_alarm == 1'b0
      && general_trip == 1'b0))
    else $error("External block did not block protection");
  a_perm_inhibit_cmd: assert property (                                             // RL3
    ctrl_q[`PROT_CTRL_PERM_INHIB] |=> (trip_command_out == '0))
    else $error("Trip command issued under permanent inhibit");
  a_temp_inhibit_cmd: assert property (                                             // RL4
    (ctrl_q[`PROT_CTRL_TEMP_PERMIT] && temp_in_s) |=> (trip_command_out == '0 && trip_inhibited))
    else $error("Trip command issued under temporary inhibit");
  a_supv_no_command: assert property (                                              // RL6
    ((trip_command_out & $past(supv_only_q)) == '0))
    else $error("Supervision-only element produced a trip command");
  a_alarm_or_forward: assert property (                                             // RL5 RL7
    general_alarm == $past(|(elem_alarm & ~supv_only_q) && active_c))
    else $error("General alarm does not match forwarded alarms");
  a_trip_or_forward: assert property (                                              // RL9
    general_trip == $past(|(elem_trip & ~supv_only_q) && active_c))
    else $error("General trip does not match forwarded trips");
  a_trip_command_issue: assert property (                                           // RL10
    (active_c && !trip_blk_c && |(elem_trip & ~supv_only_q)) |=>
      (general_trip && trip_command_out == $past(elem_trip & ~supv_only_q)))
    else $error("General trip did not issue trip commands");
  a_phase_trip_cap: assert property (                                               // RL11
    phase1_collective_trip == $past(|(elem_phase_trip[N_ELEM-1:0] & phase_cap_q & ~supv_only_q) && active_c))
    else $error("Phase one collective trip mismatch");
  a_avail_condition: assert property (                                              // RL12
    (busy_s || !meas_ok_s) |=> (!prot_available && !prot_active))
    else $error("Protection available during setting change or bad values");
  a_irq_set_wins: assert property (
    (ev_c != '0 && wr_en && addr == `PROT_OFS_IRQ_CLR) |=> ((irq_stat_q & $past(ev_c)) == $past(ev_c)))
    else $error("Interrupt event lost against a clear");

endmodule

// ===== tb/elem_model.sv
// Behavioural model of the protection elements that feed the aggregator
`timescale 1ns/10ps

module elem_model #(
  parameter int N     = 8,
  parameter int DELAY = 4
) (
  // Clock and reset
  input  wire logic           sys_clk,
  input  wire logic           rst_n,
  // Fault criteria
  input  wire logic [N-1:0]   fault,
  input  wire logic [2:0]     fault_phase,
  // Element decisions
  output logic      [N-1:0]   alarm,
  output logic      [N-1:0]   trip,
  output logic      [3*N-1:0] ph_alarm,
  output logic      [3*N-1:0] ph_trip
);
  logic [7:0] cnt_q [N];

  // ----------------------------------------------------------------
  // Alarm at once, trip only once the fault outlasts the delay
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (!rst_n)
      begin
        cnt_q[i] <= 8'h00;
        alarm[i] <= 1'b0;
        trip[i]  <= 1'b0;
      end
      else
      begin
        alarm[i] <= fault[i];
        trip[i]  <= fault[i] && (cnt_q[i] >= 8'(DELAY - 1));
        cnt_q[i] <= !fault[i] ? 8'h00 : (cnt_q[i] < 8'(DELAY)) ? cnt_q[i] + 8'h01 : cnt_q[i];
      end
    end
  end

  always_comb
  begin
    for (int p = 0; p < 3; p++)
    begin
      for (int i = 0; i < N; i++)
      begin
        ph_alarm[p*N+i] = alarm[i] & fault_phase[p];
        ph_trip[p*N+i]  = trip[i] & fault_phase[p];
      end
    end
  end
endmodule

// ===== tb/tb.sv
// Self-checking testbench of the protection trip aggregator
`timescale 1ns/10ps
`include "prot_defs.svh"

module tb;
  import prot_pkg::*;
  localparam int N = 8;
  localparam int DELAY = 4;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  reg_addr_t addr = 8'h00;
  reg_data_t wr_data = 32'h0;
  reg_data_t rd_data;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic block_input_a = 1'b0;
  logic block_input_b = 1'b0;
  logic temp_trip_inhibit_input = 1'b0;
  logic setting_change_busy = 1'b0;
  logic meas_ok = 1'b1;
  logic [N-1:0] fault = 8'h00;
  logic [2:0] fault_phase = 3'h1;
  logic [N-1:0] elem_alarm, elem_trip, trip_command_out;
  logic [3*N-1:0] elem_phase_alarm, elem_phase_trip;
  logic prot_available, prot_active, master_blocked_state, trip_inhibited, general_alarm, general_trip, irq;
  logic p1a, p2a, p3a, p1t, p2t, p3t;
  logic [4:0] st;
  logic [5:0] ph;
  int fail_count = 0;
  int check_count = 0;

  assign st = {general_alarm, general_trip, prot_active, master_blocked_state, trip_inhibited};
  assign ph = {p3t, p2t, p1t, p3a, p2a, p1a};

  always #2.5 sys_clk = ~sys_clk;

  elem_model #(.N(N), .DELAY(DELAY)) elems (.sys_clk(sys_clk), .rst_n(rst_n), .fault(fault),
    .fault_phase(fault_phase), .alarm(elem_alarm), .trip(elem_trip), .ph_alarm(elem_phase_alarm),
    .ph_trip(elem_phase_trip));

  protection_trip_aggregator #(.N_ELEM(N)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .block_input_a(block_input_a),
    .block_input_b(block_input_b), .temp_trip_inhibit_input(temp_trip_inhibit_input),
    .setting_change_busy(setting_change_busy), .meas_ok(meas_ok), .elem_alarm(elem_alarm),
    .elem_trip(elem_trip), .elem_phase_alarm(elem_phase_alarm), .elem_phase_trip(elem_phase_trip),
    .prot_available(prot_available), .prot_active(prot_active), .master_blocked_state(master_blocked_state),
    .trip_inhibited(trip_inhibited), .general_alarm(general_alarm), .general_trip(general_trip),
    .phase1_collective_alarm(p1a), .phase2_collective_alarm(p2a), .phase3_collective_alarm(p3a),
    .phase1_collective_trip(p1t), .phase2_collective_trip(p2t), .phase3_collective_trip(p3t),
    .trip_command_out(trip_command_out), .irq(irq));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    @(negedge sys_clk);
    chk(rd_data, exp);
  endtask

  task automatic done(input string name);
    $display("Test %s finished at %0t", name, $time);
  endtask

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #(5 * 5000);
    fail_count++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    wt(6);
    rdc(`PROT_OFS_CTRL, 32'h1);
    rdc(`PROT_OFS_SUPV_ONLY, 32'h0);
    rdc(`PROT_OFS_PHASE_CAP, 32'hff);
    rdc(`PROT_OFS_IRQ_EN, 32'h0);
    rdc(`PROT_OFS_IRQ_STAT, 32'h0);
    wr(8'h1c, 32'hff);
    rdc(8'h1c, 32'h0);
    rdc(`PROT_OFS_STATUS, 32'hc);
    wt(1);
    chk(rd_data, 32'h0);
    done("registers");

    @(posedge sys_clk);
    fault <= 8'h04;
    wt(1);
    chk(st, 5'b00100);
    wt(1);
    chk(st, 5'b10100);
    wt(2);
    chk(general_trip, 1'b0);
    wt(1);
    chk(st, 5'b11100);
    chk(trip_command_out, 8'h04);
    chk(ph, 6'b001001);
    rdc(`PROT_OFS_IRQ_STAT, 32'h3);
    chk(irq, 1'b0);
    wr(`PROT_OFS_IRQ_EN, 32'h1);
    wt(1);
    chk(irq, 1'b1);
    wr(`PROT_OFS_IRQ_CLR, 32'h3);
    wt(1);
    chk(irq, 1'b0);
    rdc(`PROT_OFS_IRQ_STAT, 32'h0);
    done("forwarding");

    @(posedge sys_clk);
    fault <= 8'h24;
    wt(DELAY + 2);
    chk(trip_command_out, 8'h24);
    wr(`PROT_OFS_SUPV_ONLY, 32'h24);
    wt(1);
    chk(st, 5'b00100);
    chk(trip_command_out, 8'h00);
    chk(ph, 6'b000000);
    wr(`PROT_OFS_SUPV_ONLY, 32'h04);
    wt(1);
    chk(trip_command_out, 8'h20);
    wr(`PROT_OFS_PHASE_CAP, 32'hdf);
    wt(1);
    chk(ph, 6'b000000);
    chk(st, 5'b11100);
    wr(`PROT_OFS_PHASE_CAP, 32'hff);
    @(posedge sys_clk);
    fault_phase <= 3'h6;
    wt(2);
    chk(ph, 6'b110110);
    done("supervision");

    wr(`PROT_OFS_CTRL, 32'h5);
    wt(1);
    chk(st, 5'b11101);
    chk(trip_command_out, 8'h00);
    wr(`PROT_OFS_CTRL, 32'h1);
    @(posedge sys_clk);
    temp_trip_inhibit_input <= 1'b1;
    wt(4);
    chk(trip_command_out, 8'h20);
    wr(`PROT_OFS_CTRL, 32'h9);
    wt(1);
    chk(st, 5'b11101);
    chk(trip_command_out, 8'h00);
    @(posedge sys_clk);
    temp_trip_inhibit_input <= 1'b0;
    wt(4);
    chk(trip_command_out, 8'h20);
    done("trip_inhibit");

    @(posedge sys_clk);
    block_input_a <= 1'b1;
    wt(4);
    chk(st, 5'b11100);
    wr(`PROT_OFS_CTRL, 32'h3);
    wt(1);
    chk(st, 5'b00010);
    chk({trip_command_out, ph}, 14'h0);
    @(posedge sys_clk);
    block_input_a <= 1'b0;
    block_input_b <= 1'b1;
    wt(6);
    chk(st, 5'b00010);
    @(posedge sys_clk);
    block_input_b <= 1'b0;
    wt(4);
    chk(st, 5'b11100);
    chk(trip_command_out, 8'h20);
    rdc(`PROT_OFS_IRQ_STAT, 32'h7);
    wr(`PROT_OFS_IRQ_CLR, 32'hf);
    done("block");

    wr(`PROT_OFS_CTRL, 32'h0);
    wt(1);
    chk(st, 5'b00000);
    chk(trip_command_out, 8'h00);
    wr(`PROT_OFS_CTRL, 32'h1);
    @(posedge sys_clk);
    meas_ok <= 1'b0;
    wt(4);
    chk({prot_available, st}, 6'b000000);
    rdc(`PROT_OFS_IRQ_STAT, 32'hb);
    wr(`PROT_OFS_IRQ_EN, 32'h8);
    wt(1);
    chk(irq, 1'b1);
    wr(`PROT_OFS_IRQ_CLR, 32'h8);
    wt(1);
    chk(irq, 1'b0);
    @(posedge sys_clk);
    meas_ok <= 1'b1;
    setting_change_busy <= 1'b1;
    wt(6);
    chk({prot_available, prot_active}, 2'b00);
    @(posedge sys_clk);
    setting_change_busy <= 1'b0;
    wt(4);
    rdc(`PROT_OFS_STATUS, 32'hf);
    @(posedge sys_clk);
    fault <= 8'h00;
    wt(3);
    chk(st, 5'b00100);
    wr(`PROT_OFS_IRQ_CLR, 32'hf);
    @(posedge sys_clk);
    fault <= 8'h01;
    // Clear lands on the edge that latches the alarm rise
    wr(`PROT_OFS_IRQ_CLR, 32'h2);
    rdc(`PROT_OFS_IRQ_STAT, 32'h2);
    done("availability");
    stop_test();
  end
endmodule
